//--- spi_cmd_fifo.sv
// small command fifo with valid and ready on both sides
`timescale 1ns/1ns
module spi_cmd_fifo #(
	parameter int unsigned WIDTH = 20,
	parameter int unsigned DEPTH = spi_word_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic push;
	logic pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			wr_r <= '0;
			rd_r <= '0;
			in_ready <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
endmodule : spi_cmd_fifo

//--- spi_master_word_engine.sv
// spi master word engine with command fifo
`timescale 1ns/1ns
module spi_master_word_engine #(
	parameter int unsigned HALF_CYC = spi_word_pkg::HALF_CYC,
	parameter int unsigned FIFO_DEPTH = spi_word_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] cfg_mode,
	input wire logic cfg_cs_active_high,
	input wire logic cfg_strobe_en,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_bits_m1,
	input wire logic [15:0] cmd_data,
	output logic cmd_ready,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic cs_out,
	output logic load_strobe,
	output logic [15:0] rx_data,
	output logic rx_valid,
	output logic busy
);
	if (HALF_CYC < 2 || HALF_CYC > 65535) begin : g_bad_half
		$error("half period must lie between 2 and 65535 cycles");
	end
	localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

	spi_word_pkg::eng_state_t state_r;
	spi_word_pkg::eng_state_t state_nxt;
	logic miso_q1_r;
	logic miso_s_r;
	logic [15:0] hcnt_r;
	logic [4:0] ecnt_r;
	logic [3:0] nbits_r;
	logic [1:0] mode_r;
	logic le_r;
	logic csh_r;
	logic [15:0] tx_r;
	logic [15:0] rx_r;
	logic [4:0] samp_cnt_r;
	logic sclk_r;
	logic mosi_r;
	logic cs_r;
	logic strobe_r;
	logic [15:0] rx_data_r;
	logic rx_valid_r;
	logic busy_r;
	logic f_valid;
	logic [19:0] f_data;
	logic start;
	logic tick;
	logic edge_ev;
	logic last_edge;
	logic cpha;
	logic sample_en;
	logic drive_en;
	logic [15:0] aligned;

	spi_cmd_fifo #(
		.WIDTH(20),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(cmd_valid),
		.in_data({cmd_bits_m1, cmd_data}),
		.in_ready(cmd_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(state_r == spi_word_pkg::ST_IDLE)
	);

	// miso synchroniser
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			miso_q1_r <= 1'b0;
			miso_s_r <= 1'b0;
		end else begin
			miso_q1_r <= miso;
			miso_s_r <= miso_q1_r;
		end
	end

	assign start = (state_r == spi_word_pkg::ST_IDLE) && f_valid;
	assign tick = (hcnt_r == HALF_LAST);
	assign edge_ev = (state_r == spi_word_pkg::ST_SHIFT) && tick;
	assign last_edge = (ecnt_r == {nbits_r, 1'b1});
	assign cpha = mode_r[0] ^ mode_r[1];
	// sample on leading edge for modes 0 and 3, trailing for 1 and 2
	assign sample_en = edge_ev && (ecnt_r[0] == cpha);
	assign drive_en = edge_ev && (ecnt_r[0] != cpha);
	// left-align the word so its msb leaves first
	assign aligned = f_data[15:0] << (4'hf - f_data[19:16]);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			spi_word_pkg::ST_IDLE: begin
				if (f_valid) begin
					state_nxt = spi_word_pkg::ST_LEAD;
				end
			end
			spi_word_pkg::ST_LEAD: begin
				if (tick) begin
					state_nxt = spi_word_pkg::ST_SHIFT;
				end
			end
			spi_word_pkg::ST_SHIFT: begin
				if (tick && last_edge) begin
					state_nxt = spi_word_pkg::ST_TRAIL;
				end
			end
			spi_word_pkg::ST_TRAIL: begin
				if (tick) begin
					state_nxt = le_r ? spi_word_pkg::ST_STROBE : spi_word_pkg::ST_IDLE;
				end
			end
			spi_word_pkg::ST_STROBE: begin
				if (tick) begin
					state_nxt = spi_word_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = spi_word_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= spi_word_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// half period timer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hcnt_r <= 16'h0000;
		end else if (state_r == spi_word_pkg::ST_IDLE || tick) begin
			hcnt_r <= 16'h0000;
		end else begin
			hcnt_r <= hcnt_r + 16'h0001;
		end
	end

	// edge counter
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ecnt_r <= 5'h00;
		end else if (start) begin
			ecnt_r <= 5'h00;
		end else if (edge_ev) begin
			ecnt_r <= ecnt_r + 5'h01;
		end
	end

	// per-transfer settings
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= 2'h0;
			le_r <= 1'b0;
			csh_r <= 1'b0;
			nbits_r <= 4'h0;
		end else if (start) begin
			mode_r <= cfg_mode;
			le_r <= cfg_strobe_en;
			csh_r <= cfg_cs_active_high;
			nbits_r <= f_data[19:16];
		end
	end

	// serial clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sclk_r <= spi_word_pkg::RST_SCLK;
		end else if (state_r == spi_word_pkg::ST_IDLE) begin
			sclk_r <= cfg_mode[1];
		end else if (edge_ev) begin
			sclk_r <= ~sclk_r;
		end
	end

	// transmit shifter
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_r <= 16'h0000;
			mosi_r <= 1'b0;
		end else if (start) begin
			mosi_r <= aligned[15];
			tx_r <= (cfg_mode[0] ^ cfg_mode[1]) ? aligned : (aligned << 1);
		end else if (drive_en) begin
			mosi_r <= tx_r[15];
			tx_r <= tx_r << 1;
		end
	end

	// receive shifter
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_r <= spi_word_pkg::RST_RX;
			samp_cnt_r <= 5'h00;
		end else if (start) begin
			rx_r <= spi_word_pkg::RST_RX;
			samp_cnt_r <= 5'h00;
		end else if (sample_en) begin
			rx_r <= {rx_r[14:0], miso_s_r};
			samp_cnt_r <= samp_cnt_r + 5'h01;
		end
	end

	// chip select
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cs_r <= spi_word_pkg::RST_CS;
		end else if (start) begin
			cs_r <= cfg_cs_active_high;
		end else if (state_r == spi_word_pkg::ST_IDLE) begin
			cs_r <= ~cfg_cs_active_high;
		end else if (state_r == spi_word_pkg::ST_TRAIL && tick) begin
			cs_r <= ~csh_r;
		end
	end

	// load strobe, received word and busy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strobe_r <= 1'b0;
			rx_data_r <= spi_word_pkg::RST_RX;
			rx_valid_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			strobe_r <= (state_nxt == spi_word_pkg::ST_STROBE);
			busy_r <= (state_nxt != spi_word_pkg::ST_IDLE);
			rx_valid_r <= (state_r == spi_word_pkg::ST_TRAIL) && tick;
			if (state_r == spi_word_pkg::ST_TRAIL && tick) begin
				rx_data_r <= rx_r;
			end
		end
	end

	assign sclk = sclk_r;
	assign mosi = mosi_r;
	assign cs_out = cs_r;
	assign load_strobe = strobe_r;
	assign rx_data = rx_data_r;
	assign rx_valid = rx_valid_r;
	assign busy = busy_r;

	AST_MODE0_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(sample_en && mode_r == 2'h0) |=> $rose(sclk_r))
		else $error("mode 0 sample not on rising clock");
	AST_MODE1_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(sample_en && mode_r == 2'h1) |=> $fell(sclk_r))
		else $error("mode 1 sample not on falling clock");
	AST_MODE2_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(sample_en && mode_r == 2'h2) |=> $rose(sclk_r))
		else $error("mode 2 sample not on rising clock");
	AST_MODE3_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(sample_en && mode_r == 2'h3) |=> $fell(sclk_r))
		else $error("mode 3 sample not on falling clock");
	AST_IDLE_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_r == spi_word_pkg::ST_TRAIL) |-> (sclk_r == mode_r[1]))
		else $error("clock not at idle level after word");
	AST_CS_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_r == spi_word_pkg::ST_IDLE && $stable(cfg_cs_active_high)
		&& $past(state_r == spi_word_pkg::ST_IDLE)) |-> (cs_r == !cfg_cs_active_high))
		else $error("chip select active while idle");
	AST_CS_ACTIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_r == spi_word_pkg::ST_SHIFT) |-> (cs_r == csh_r))
		else $error("chip select not active during shift");
	AST_NO_STROBE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(strobe_r) |-> le_r)
		else $error("strobe sent while disabled");
	AST_BIT_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rx_valid_r |-> (samp_cnt_r == {1'b0, nbits_r} + 5'h01))
		else $error("captured bit count differs from word length");
	AST_STROBE_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		strobe_r |-> (sclk_r == mode_r[1] && cs_r == !csh_r))
		else $error("strobe while clock or select active");
	AST_START_CS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start |=> (cs_r == csh_r) ##1 (state_r == spi_word_pkg::ST_LEAD))
		else $error("select not asserted at transfer start");
	AST_SCLK_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_r == spi_word_pkg::ST_IDLE && $past(rst_n)
		&& $past(state_r == spi_word_pkg::ST_IDLE)) |-> (sclk_r == $past(cfg_mode[1])))
		else $error("idle clock level differs from selected mode");
	AST_SCLK_STEADY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_r != spi_word_pkg::ST_IDLE && $past(state_r != spi_word_pkg::ST_IDLE)
		&& !$past(edge_ev)) |-> $stable(sclk_r))
		else $error("serial clock moved between half periods");
	AST_MOSI_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!$past(drive_en) && !$past(start)) |-> $stable(mosi_r))
		else $error("data output moved off its drive edge");
	AST_STROBE_AFTER_WORD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(strobe_r) |-> $past(state_r == spi_word_pkg::ST_TRAIL))
		else $error("strobe not directly after the word");
	AST_RX_FITS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rx_valid_r |-> ((rx_data_r >> ({1'b0, nbits_r} + 5'h01)) == 16'h0000))
		else $error("received word wider than word length");
endmodule : spi_master_word_engine

//--- spi_master_word_engine_tb.sv
// self-checking bench for the spi master word engine
`timescale 1ns/1ns
module spi_master_word_engine_tb;
	localparam int unsigned H = 6;
	logic clk_sys;
	logic rst_n;
	logic [1:0] cfg_mode;
	logic cfg_cs_active_high;
	logic cfg_strobe_en;
	logic cmd_valid;
	logic [3:0] cmd_bits_m1;
	logic [15:0] cmd_data;
	logic cmd_ready;
	logic miso;
	logic sclk;
	logic mosi;
	logic cs_out;
	logic load_strobe;
	logic [15:0] rx_data;
	logic rx_valid;
	logic busy;
	logic [15:0] resp;
	logic [15:0] got;
	logic prev_strobe;
	logic sel_tb;
	int cnt;
	int n;
	int i;
	int err_count = 0;
	int num_checks = 0;
	int strobes = 0;
	int cycles = 0;
	time last_edge = 0;
	int lead_mul = 2;
	assign sel_tb = (cs_out === cfg_cs_active_high);
	spi_master_word_engine #(.HALF_CYC(H), .FIFO_DEPTH(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.cfg_mode(cfg_mode), .cfg_cs_active_high(cfg_cs_active_high),
		.cfg_strobe_en(cfg_strobe_en), .cmd_valid(cmd_valid), .cmd_bits_m1(cmd_bits_m1),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .miso(miso), .sclk(sclk), .mosi(mosi),
		.cs_out(cs_out), .load_strobe(load_strobe), .rx_data(rx_data), .rx_valid(rx_valid),
		.busy(busy));
	spi_slave_model slave (.sclk(sclk), .mosi(mosi), .cs_out(cs_out),
		.cs_active_high(cfg_cs_active_high), .mode(cfg_mode), .bits_m1(cmd_bits_m1),
		.resp(resp), .miso(miso), .got(got), .cnt(cnt));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input string w, input logic [15:0] e, input logic [15:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", w, e, s);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	task automatic wait_rx();
		for (int k = 0; k < 600 && rx_valid !== 1'b1; k++) @(negedge clk_sys);
	endtask : wait_rx
	task automatic xfer(input logic [1:0] m, input logic pol, input logic se,
		input logic [3:0] nm1, input logic [15:0] d, input logic [15:0] r);
		logic [15:0] mask;
		int s0;
		mask = 16'hffff >> (4'hf - nm1);
		cfg_mode = m;
		cfg_cs_active_high = pol;
		cfg_strobe_en = se;
		resp = r;
		repeat (2) @(negedge clk_sys);
		check("idle sclk", {15'h0, m[1]}, {15'h0, sclk});
		check("idle select", {15'h0, !pol}, {15'h0, cs_out});
		s0 = strobes;
		cmd_bits_m1 = nm1;
		cmd_data = d & mask;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		wait_rx();
		check("rx_valid", 16'h0001, {15'h0, rx_valid});
		check("rx_data", r & mask, rx_data);
		check("bit count", {12'h0, nm1} + 16'h0001, 16'(cnt));
		check("slave word", d & mask, got);
		for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk_sys);
		check("end sclk", {15'h0, m[1]}, {15'h0, sclk});
		check("end select", {15'h0, !pol}, {15'h0, cs_out});
		check("strobes", {15'h0, se}, 16'(strobes - s0));
	endtask : xfer
	// select leads the first clock edge by two half periods, then even spacing
	always @(posedge sel_tb) begin
		last_edge = $time;
		lead_mul = 2;
	end
	always @(sclk) begin
		if (busy === 1'b1 && sel_tb) begin
			check("half period", 16'(lead_mul * H * 10), 16'($time - last_edge));
			last_edge = $time;
			lead_mul = 1;
		end
	end
	always @(negedge clk_sys) begin
		cycles++;
		if (load_strobe === 1'b1 && prev_strobe !== 1'b1) begin
			strobes++;
			check("strobe sclk", {15'h0, cfg_mode[1]}, {15'h0, sclk});
			check("strobe select", {15'h0, !cfg_cs_active_high}, {15'h0, cs_out});
		end
		prev_strobe = load_strobe;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end
	initial begin
		rst_n = 1'b0;
		cfg_mode = 2'h0;
		cfg_cs_active_high = 1'b0;
		cfg_strobe_en = 1'b0;
		cmd_valid = 1'b0;
		cmd_bits_m1 = 4'h0;
		cmd_data = 16'h0000;
		resp = 16'h0000;
		prev_strobe = 1'b0;
		repeat (5) @(negedge clk_sys);
		rst_n = 1'b1;
		xfer(2'h0, 1'b0, 1'b1, 4'hf, 16'hb38d, 16'h5a3c);
		xfer(2'h1, 1'b1, 1'b0, 4'h0, 16'h0001, 16'h8001);
		xfer(2'h2, 1'b0, 1'b0, 4'h7, 16'h00c5, 16'h1234);
		xfer(2'h3, 1'b1, 1'b1, 4'hb, 16'h0a5f, 16'hfedc);
		xfer(2'h1, 1'b0, 1'b1, 4'hf, 16'h8000, 16'h0001);
		// back to back words until the fifo refuses, then one refused push
		cfg_mode = 2'h0;
		cfg_strobe_en = 1'b0;
		resp = 16'h00c3;
		cmd_bits_m1 = 4'h7;
		cmd_valid = 1'b1;
		for (n = 0; n < 8 && cmd_ready === 1'b1; n++) begin
			cmd_data = 16'(n * 37 + 5);
			@(negedge clk_sys);
		end
		cmd_data = 16'h00ee;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// four words queued plus one taken by the idle engine at once
		check("fifo words", 16'h0005, 16'(n));
		for (i = 0; i < n; i++) begin
			@(negedge clk_sys);
			wait_rx();
			check("burst rx", 16'h00c3, rx_valid === 1'b1 ? rx_data : 16'hffff);
			check("burst order", 16'(i * 37 + 5), got);
		end
		@(negedge clk_sys);
		wait_rx();
		check("refused word", 16'h0000, {15'h0, rx_valid});
		results();
	end
endmodule : spi_master_word_engine_tb

//--- spi_slave_model.sv
// behavioural spi slave answering the word engine
`timescale 1ns/1ns
module spi_slave_model (
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cs_out,
	input wire logic cs_active_high,
	input wire logic [1:0] mode,
	input wire logic [3:0] bits_m1,
	input wire logic [15:0] resp,
	output logic miso,
	output logic [15:0] got,
	output int cnt
);
	logic sel;
	logic first;
	int p;
	assign sel = (cs_out === cs_active_high);
	initial begin
		miso = 1'b0;
		got = 16'h0000;
		cnt = 0;
		first = 1'b0;
		p = 0;
	end
	// frame start loads the answer, frame end lets the line wander
	always @(sel) begin
		if (sel) begin
			got = 16'h0000;
			cnt = 0;
			p = int'(bits_m1);
			first = (mode[0] != mode[1]);
			miso = first ? ~miso : resp[p];
		end else begin
			miso = ~miso;
		end
	end
	// capture on the sample edge, shift out on the other one
	always @(sclk) begin
		if (sel && sclk === !mode[0]) begin
			got = {got[14:0], mosi};
			cnt++;
		end else if (sel) begin
			if (first) first = 1'b0;
			else if (p > 0) p--;
			miso = resp[p];
		end
	end
endmodule : spi_slave_model

//--- spi_word_pkg.sv
// constants for the spi master word engine
package spi_word_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BIT_RATE_HZ = 330_000;
	// half a bit period, rounded down so the rate is never below nominal
	localparam int unsigned HALF_CYC = CLK_HZ / (2 * BIT_RATE_HZ);
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned LEN_W = 4;
	localparam logic RST_CS = 1'b1;
	localparam logic RST_SCLK = 1'b0;
	localparam logic [15:0] RST_RX = 16'h0000;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LEAD = 5'b00010,
		ST_SHIFT = 5'b00100,
		ST_TRAIL = 5'b01000,
		ST_STROBE = 5'b10000
	} eng_state_t;
endpackage : spi_word_pkg
